// file: common/airmc_if.sv
// link between the host controller and the amplifier control logic
`timescale 1ns/100ps
`default_nettype none
interface airmc_if;
   logic hard_reset_n;
   logic req;
   logic we;
   airmc_pkg::airmc_byte_t addr;
   airmc_pkg::airmc_byte_t wdata;
   airmc_pkg::airmc_byte_t rdata;
   logic ack;
   logic [9:0] irq_pin;
   logic [9:0] irq_pin_oe;
   modport device (input hard_reset_n, req, we, addr, wdata,
                   output rdata, ack, irq_pin, irq_pin_oe);
   modport host (output hard_reset_n, req, we, addr, wdata,
                 input rdata, ack, irq_pin, irq_pin_oe);
endinterface : airmc_if
`default_nettype wire

// file: common/airmc_map.svh
// register offsets, field positions, reset values and timing of the amplifier control block
`ifndef AIRMC_MAP_SVH
`define AIRMC_MAP_SVH
// device register offsets on the link
`define AIRMC_SOFT_RESET 8'h00
`define AIRMC_POWER_CTRL 8'h01
`define AIRMC_SLEEP_CTRL 8'h02
`define AIRMC_MODE_SEL 8'h03
`define AIRMC_SPREAD_CTRL 8'h04
`define AIRMC_RAMP_CTRL 8'h05
`define AIRMC_STICKY_A 8'h06
`define AIRMC_STICKY_B 8'h07
`define AIRMC_ROUTE_BASE 8'h08
`define AIRMC_PIN_BASE 8'h10
// writable field masks, reserved bits read zero
`define AIRMC_MASK_POWER 8'h01
`define AIRMC_MASK_SLEEP 8'h80
`define AIRMC_MASK_MODE 8'h0F
`define AIRMC_MASK_SPREAD 8'h01
`define AIRMC_MASK_RAMP 8'hB3
`define AIRMC_MASK_ROUTE 8'h77
`define AIRMC_MASK_ROUTE3 8'h7F
// reset values
`define AIRMC_RST_POWER 8'h01
`define AIRMC_RST_MODE 8'h01
`define AIRMC_RST_RAMP 8'h01
// field positions
`define AIRMC_BIT_SLEEP 7
`define AIRMC_BIT_RAMP_SRC 7
`define AIRMC_PIN_FN_LINE0 8'h07
// host apb register offsets
`define AIRMC_APB_CMD 12'h000
`define AIRMC_APB_STATUS 12'h004
`define AIRMC_APB_CTRL 12'h008
`define AIRMC_APB_MCLK 12'h00C
`define AIRMC_CMD_WE_BIT 16
// timing
`define AIRMC_CLOCK_MHZ 125
`define AIRMC_QUIET_US 100
`define AIRMC_MCLK_MIN_48K 32'h00BB8000
`define AIRMC_MCLK_MIN_44K 32'h00AC4400
`endif

// file: common/airmc_pkg.sv
// types shared by both ends of the amplifier control block
package airmc_pkg;
   typedef logic [7:0] airmc_byte_t;
   typedef enum logic [3:0] {
      AIRMC_MODE_RSVD = 4'h0,
      AIRMC_MODE_PLAY = 4'h1,
      AIRMC_MODE_SENSE = 4'h2,
      AIRMC_MODE_PROTECT = 4'h3
   } airmc_mode_e;
   typedef enum logic [2:0] {
      AIRMC_H_HELD = 3'h0,
      AIRMC_H_BOOT = 3'h1,
      AIRMC_H_QUIET = 3'h2,
      AIRMC_H_IDLE = 3'h3,
      AIRMC_H_ACCESS = 3'h4,
      AIRMC_H_SHUT = 3'h5
   } airmc_host_state_e;
endpackage : airmc_pkg

// file: logic/airmc_device.sv
// amplifier control logic: sticky flags, interrupt routing, reset, shutdown and modes
// Operation
// - spread enable bit switches ramp modulation
// - host enables spread only with internal oscillator
// - depth code 01 is 5, 10 is 10
// - four interrupt lines onto ten pins
// - shared line is OR of its flags
// - host reads sticky flags after shared interrupt
// - fixed sticky bit positions in two registers
// - three-bit route per flag, four bits for ce2, 001 first line
// - pin function 0x07 drives first line
// - reset bit restores defaults, self clearing
// - host stays off bus 100 us after reset
// - host soft resets after every hard release
// - hard reset low stops all, ignores bus
// - hard release comes up in software shutdown
// - host shuts down before asserting hard reset
// - shutdown powers analog down, keeps registers
// - sleep bit disables battery reset monitor
// - mode codes 1 play, 2 sense, 3 protect
// - play mode keeps sense off, no protection
// - sense mode powers sense, returns samples
// - host disables pll only with fast mclk
// - sticky flag holds until read or reset
`timescale 1ns/100ps
`default_nettype none
`include "airmc_map.svh"
module airmc_device #(
   parameter int NUM_PINS = 10,
   parameter int NUM_LINES = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // link to the host
   airmc_if.device link,
   // fault events, one-cycle pulses: oc, uv, ot, bo, cl, sc, ce1, ce2 from bit 0
   input wire logic [7:0] flag_events,
   // analog and dsp controls
   output logic analog_power_on,
   output logic battery_monitor_on,
   output logic spread_on,
   output logic [1:0] modulation_depth,
   output logic ramp_from_oscillator,
   output logic [1:0] ramp_frequency,
   output logic sense_power_on,
   output logic sense_return_on,
   output logic protection_run
);
   generate
      if (NUM_PINS != 10 || NUM_LINES != 4) begin : g_check
         $error("airmc_device serves ten pins and four lines only");
      end
   endgenerate

   logic [7:0] soft_reset_control;
   logic [7:0] power_control;
   logic [7:0] sleep_control;
   logic [7:0] processing_mode_select;
   logic [7:0] spread_spectrum_control;
   logic [7:0] ramp_control;
   logic [7:0] sticky_flags_first;
   logic [7:0] sticky_flags_second;
   logic [7:0] flag_routing [4];
   logic [7:0] pin_function_config [NUM_PINS];
   logic ack;
   logic [7:0] rdata;
   logic [NUM_PINS-1:0] irq_pin;
   logic [NUM_PINS-1:0] irq_pin_oe;

   // hard reset, host reset and the soft reset strobe all clear the register file
   wire reg_reset = reset | ~link.hard_reset_n | soft_reset_control[0];
   // a request is taken once; the bus is deaf while any reset is active
   wire accept = link.req & ~ack & ~reg_reset;
   wire wr = accept & link.we;
   wire rd = accept & ~link.we;
   wire wr_soft = wr & (link.addr == `AIRMC_SOFT_RESET) & link.wdata[0];
   wire wr_power = wr & (link.addr == `AIRMC_POWER_CTRL);
   wire wr_sleep = wr & (link.addr == `AIRMC_SLEEP_CTRL);
   wire wr_mode = wr & (link.addr == `AIRMC_MODE_SEL);
   wire wr_spread = wr & (link.addr == `AIRMC_SPREAD_CTRL);
   wire wr_ramp = wr & (link.addr == `AIRMC_RAMP_CTRL);
   wire rd_sticky_a = rd & (link.addr == `AIRMC_STICKY_A);
   wire rd_sticky_b = rd & (link.addr == `AIRMC_STICKY_B);
   wire [7:0] route_index = link.addr - `AIRMC_ROUTE_BASE;
   wire [7:0] pin_index = link.addr - `AIRMC_PIN_BASE;
   wire route_hit = (link.addr >= `AIRMC_ROUTE_BASE) && (route_index < 8'h04);
   wire pin_hit = (link.addr >= `AIRMC_PIN_BASE) && (pin_index < 8'(NUM_PINS));

   // event pulses placed at their sticky bit positions
   wire [7:0] set_first = {flag_events[0], flag_events[1], 1'b0, flag_events[2],
                           flag_events[3], flag_events[4], flag_events[5], 1'b0};
   wire [7:0] set_second = {4'h0, flag_events[6], flag_events[7], 2'h0};
   // reading clears, but an event in the same cycle wins over the clear
   wire [7:0] next_sticky_first = (sticky_flags_first & ~{8{rd_sticky_a}}) | set_first;
   wire [7:0] next_sticky_second = (sticky_flags_second & ~{8{rd_sticky_b}}) | set_second;

   // flag levels and route codes in event order
   wire [7:0] flag_level = {sticky_flags_second[2], sticky_flags_second[3],
                            sticky_flags_first[1], sticky_flags_first[2],
                            sticky_flags_first[3], sticky_flags_first[4],
                            sticky_flags_first[6], sticky_flags_first[7]};
   wire [3:0] route_code [8];
   assign route_code[0] = {1'b0, flag_routing[0][6:4]};
   assign route_code[1] = {1'b0, flag_routing[0][2:0]};
   assign route_code[2] = {1'b0, flag_routing[1][2:0]};
   assign route_code[3] = {1'b0, flag_routing[2][6:4]};
   assign route_code[4] = {1'b0, flag_routing[3][2:0]};
   assign route_code[5] = {1'b0, flag_routing[3][6:4]};
   assign route_code[6] = {1'b0, flag_routing[1][6:4]};
   // this field is four bits wide; codes above four reach no line
   assign route_code[7] = flag_routing[2][3:0];

   wire [NUM_LINES-1:0] line_level;
   wire [NUM_PINS-1:0] g_pin_drive;
   wire [NUM_PINS-1:0] g_pin_en;
   genvar gl, gf, gp;
   generate
      for (gl = 0; gl < NUM_LINES; gl++) begin : g_line
         wire [7:0] hit;
         for (gf = 0; gf < 8; gf++) begin : g_flag
            // code zero matches no line, the flag is still held sticky
            assign hit[gf] = flag_level[gf] & (route_code[gf] == 4'(gl + 1));
         end
         // level stays up while any routed flag is still unread
         assign line_level[gl] = |hit;
      end
      for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
         wire [7:0] sel = pin_function_config[gp] - `AIRMC_PIN_FN_LINE0;
         wire is_irq = (pin_function_config[gp] >= `AIRMC_PIN_FN_LINE0) && (sel < 8'h04);
         assign g_pin_drive[gp] = is_irq & line_level[sel[1:0]];
         assign g_pin_en[gp] = is_irq;
      end
   endgenerate

   // read data selection; unmapped addresses read zero
   wire [7:0] route_read = flag_routing[route_index[1:0]];
   wire [7:0] pin_read = pin_function_config[pin_index[3:0]];
   wire [7:0] read_value =
      (link.addr == `AIRMC_SOFT_RESET) ? soft_reset_control :
      (link.addr == `AIRMC_POWER_CTRL) ? power_control :
      (link.addr == `AIRMC_SLEEP_CTRL) ? sleep_control :
      (link.addr == `AIRMC_MODE_SEL) ? processing_mode_select :
      (link.addr == `AIRMC_SPREAD_CTRL) ? spread_spectrum_control :
      (link.addr == `AIRMC_RAMP_CTRL) ? ramp_control :
      (link.addr == `AIRMC_STICKY_A) ? sticky_flags_first :
      (link.addr == `AIRMC_STICKY_B) ? sticky_flags_second :
      route_hit ? route_read :
      pin_hit ? pin_read : 8'h00;

   // mode decode
   wire shut = power_control[0];
   wire [3:0] mode = processing_mode_select[3:0];
   wire sense_mode = (mode == airmc_pkg::AIRMC_MODE_SENSE) | (mode == airmc_pkg::AIRMC_MODE_PROTECT);

   // bus answer, one cycle after the request is seen
   always_ff @(posedge clock) begin
      if (reg_reset) begin
         ack <= 1'b0;
         rdata <= 8'h00;
      end else begin
         ack <= accept;
         if (rd) begin
            rdata <= read_value;
         end
      end
   end

   // self-clearing reset strobe: one cycle high, then clears everything including itself
   always_ff @(posedge clock) begin
      if (reset | ~link.hard_reset_n | soft_reset_control[0]) begin
         soft_reset_control <= 8'h00;
      end else if (wr_soft) begin
         soft_reset_control <= 8'h01;
      end
   end

   // control registers; software shutdown keeps every value
   always_ff @(posedge clock) begin
      if (reg_reset) begin
         power_control <= `AIRMC_RST_POWER;
         sleep_control <= 8'h00;
         processing_mode_select <= `AIRMC_RST_MODE;
         spread_spectrum_control <= 8'h00;
         ramp_control <= `AIRMC_RST_RAMP;
      end else begin
         if (wr_power) begin
            power_control <= link.wdata & `AIRMC_MASK_POWER;
         end
         if (wr_sleep) begin
            sleep_control <= link.wdata & `AIRMC_MASK_SLEEP;
         end
         if (wr_mode) begin
            processing_mode_select <= link.wdata & `AIRMC_MASK_MODE;
         end
         if (wr_spread) begin
            spread_spectrum_control <= link.wdata & `AIRMC_MASK_SPREAD;
         end
         if (wr_ramp) begin
            ramp_control <= link.wdata & `AIRMC_MASK_RAMP;
         end
      end
   end

   // sticky flags
   always_ff @(posedge clock) begin
      if (reg_reset) begin
         sticky_flags_first <= 8'h00;
         sticky_flags_second <= 8'h00;
      end else begin
         sticky_flags_first <= next_sticky_first;
         sticky_flags_second <= next_sticky_second;
      end
   end

   // routing and pin function tables
   always_ff @(posedge clock) begin
      if (reg_reset) begin
         for (int i = 0; i < 4; i++) begin
            flag_routing[i] <= 8'h00;
         end
         for (int i = 0; i < NUM_PINS; i++) begin
            pin_function_config[i] <= 8'h00;
         end
      end else begin
         if (wr & route_hit) begin
            flag_routing[route_index[1:0]] <= link.wdata &
               ((route_index == 8'h02) ? `AIRMC_MASK_ROUTE3 : `AIRMC_MASK_ROUTE);
         end
         if (wr & pin_hit) begin
            pin_function_config[pin_index[3:0]] <= link.wdata;
         end
      end
   end

   // registered outputs
   always_ff @(posedge clock) begin
      if (reg_reset) begin
         irq_pin <= '0;
         irq_pin_oe <= '0;
         analog_power_on <= 1'b0;
         battery_monitor_on <= 1'b1;
         spread_on <= 1'b0;
         modulation_depth <= 2'h1;
         ramp_from_oscillator <= 1'b0;
         ramp_frequency <= 2'h0;
         sense_power_on <= 1'b0;
         sense_return_on <= 1'b0;
         protection_run <= 1'b0;
      end else begin
         irq_pin <= g_pin_drive;
         irq_pin_oe <= g_pin_en;
         analog_power_on <= ~shut;
         battery_monitor_on <= ~sleep_control[`AIRMC_BIT_SLEEP];
         spread_on <= spread_spectrum_control[0];
         modulation_depth <= ramp_control[1:0];
         ramp_from_oscillator <= ramp_control[`AIRMC_BIT_RAMP_SRC];
         ramp_frequency <= ramp_control[5:4];
         sense_power_on <= ~shut & sense_mode;
         sense_return_on <= ~shut & (mode == airmc_pkg::AIRMC_MODE_SENSE);
         protection_run <= ~shut & (mode == airmc_pkg::AIRMC_MODE_PROTECT);
      end
   end

   assign link.ack = ack;
   assign link.rdata = rdata;
   assign link.irq_pin = irq_pin;
   assign link.irq_pin_oe = irq_pin_oe;
endmodule : airmc_device
`default_nettype wire

// file: logic/airmc_host.sv
// host controller: apb slave that drives the amplifier link and its reset pin
`timescale 1ns/100ps
`default_nettype none
`include "airmc_map.svh"
module airmc_host #(
   parameter int QUIET_CYCLES = `AIRMC_QUIET_US * `AIRMC_CLOCK_MHZ
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link to the device
   airmc_if.host link
);
   generate
      if (QUIET_CYCLES < 1 || QUIET_CYCLES > 65535) begin : g_check
         $error("airmc_host quiet count out of range");
      end
   endgenerate

   airmc_pkg::airmc_host_state_e state;
   logic [15:0] quiet_count;
   logic req, we, hard_reset_n, refused, ramp_osc, family_44k, pll_off_ok;
   logic [7:0] addr, wdata, last_rdata;
   logic [3:0] mode;
   logic [31:0] mclk_hz;

   wire access = psel & penable & ~pready;
   wire apb_wr = access & pwrite;
   wire cmd_wr = apb_wr & (paddr == `AIRMC_APB_CMD);
   wire ctrl_wr = apb_wr & (paddr == `AIRMC_APB_CTRL);
   wire mclk_wr = apb_wr & (paddr == `AIRMC_APB_MCLK);
   wire mapped = (paddr == `AIRMC_APB_CMD) | (paddr == `AIRMC_APB_STATUS) |
                 (paddr == `AIRMC_APB_CTRL) | (paddr == `AIRMC_APB_MCLK);
   wire idle = (state == airmc_pkg::AIRMC_H_IDLE);
   wire [7:0] c_addr = pwdata[7:0];
   wire [7:0] c_data = pwdata[15:8];
   wire c_we = pwdata[`AIRMC_CMD_WE_BIT];
   // spread may only go on after the ramp is moved to the oscillator
   wire bad_spread = c_we & (c_addr == `AIRMC_SPREAD_CTRL) & c_data[0] & ~ramp_osc;
   wire cmd_ok = cmd_wr & idle & ~bad_spread;
   wire sent_soft = we & (addr == `AIRMC_SOFT_RESET) & wdata[0];
   wire irq_any = |(link.irq_pin & link.irq_pin_oe);
   wire [31:0] status = {6'h00, link.irq_pin & link.irq_pin_oe, last_rdata,
                         3'h0, irq_any, pll_off_ok, ~hard_reset_n, refused, ~idle};
   wire [31:0] read_value =
      (paddr == `AIRMC_APB_STATUS) ? status :
      (paddr == `AIRMC_APB_CTRL) ? {30'h0, family_44k, ~hard_reset_n} :
      (paddr == `AIRMC_APB_MCLK) ? mclk_hz : 32'h00000000;
   wire [31:0] mclk_min = family_44k ? `AIRMC_MCLK_MIN_44K : `AIRMC_MCLK_MIN_48K;

   // apb answer: one wait state, unmapped addresses raise pslverr
   always_ff @(posedge clock) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= access;
         pslverr <= access & ~mapped;
         prdata <= (access & ~pwrite) ? read_value : 32'h00000000;
      end
   end

   // plain host settings
   always_ff @(posedge clock) begin
      if (reset) begin
         mclk_hz <= 32'h00000000;
         family_44k <= 1'b0;
         pll_off_ok <= 1'b0;
      end else begin
         if (mclk_wr) begin
            mclk_hz <= pwdata;
         end
         if (ctrl_wr) begin
            family_44k <= pwdata[1];
         end
         pll_off_ok <= (mode == airmc_pkg::AIRMC_MODE_PLAY) & (mclk_hz >= mclk_min);
      end
   end

   // link sequencer
   always_ff @(posedge clock) begin
      if (reset) begin
         state <= airmc_pkg::AIRMC_H_HELD;
         hard_reset_n <= 1'b0;
         req <= 1'b0;
         we <= 1'b0;
         addr <= 8'h00;
         wdata <= 8'h00;
         refused <= 1'b0;
         quiet_count <= 16'h0000;
         last_rdata <= 8'h00;
         ramp_osc <= 1'b0;
         mode <= 4'h1;
      end else begin
         if (cmd_wr | ctrl_wr) begin
            refused <= 1'b0;
         end
         unique case (state)
            airmc_pkg::AIRMC_H_HELD: begin
               if (ctrl_wr & ~pwdata[0]) begin
                  // every release is followed at once by a soft reset
                  hard_reset_n <= 1'b1;
                  req <= 1'b1;
                  we <= 1'b1;
                  addr <= `AIRMC_SOFT_RESET;
                  wdata <= 8'h01;
                  state <= airmc_pkg::AIRMC_H_BOOT;
               end else if (cmd_wr) begin
                  refused <= 1'b1;
               end
            end
            airmc_pkg::AIRMC_H_IDLE: begin
               if (ctrl_wr & pwdata[0]) begin
                  // park the amplifier in shutdown first to avoid a pop
                  req <= 1'b1;
                  we <= 1'b1;
                  addr <= `AIRMC_POWER_CTRL;
                  wdata <= `AIRMC_RST_POWER;
                  state <= airmc_pkg::AIRMC_H_SHUT;
               end else if (cmd_ok) begin
                  req <= 1'b1;
                  we <= c_we;
                  addr <= c_addr;
                  wdata <= c_data;
                  state <= airmc_pkg::AIRMC_H_ACCESS;
               end else if (cmd_wr) begin
                  refused <= 1'b1;
               end
            end
            airmc_pkg::AIRMC_H_QUIET: begin
               if (cmd_wr | ctrl_wr) begin
                  refused <= 1'b1;
               end
               if (quiet_count == 16'h0000) begin
                  state <= airmc_pkg::AIRMC_H_IDLE;
               end else begin
                  quiet_count <= quiet_count - 16'h0001;
               end
            end
            default: begin
               if (cmd_wr | ctrl_wr) begin
                  refused <= 1'b1;
               end
               if (link.ack) begin
                  req <= 1'b0;
                  if (~we) begin
                     last_rdata <= link.rdata;
                  end
                  if (we & (addr == `AIRMC_RAMP_CTRL)) begin
                     ramp_osc <= wdata[`AIRMC_BIT_RAMP_SRC];
                  end
                  if (we & (addr == `AIRMC_MODE_SEL)) begin
                     mode <= wdata[3:0];
                  end
                  if (state == airmc_pkg::AIRMC_H_SHUT) begin
                     hard_reset_n <= 1'b0;
                     state <= airmc_pkg::AIRMC_H_HELD;
                  end else if (sent_soft) begin
                     // device registers are back at defaults
                     ramp_osc <= 1'b0;
                     mode <= 4'h1;
                     quiet_count <= 16'(QUIET_CYCLES - 1);
                     state <= airmc_pkg::AIRMC_H_QUIET;
                  end else begin
                     state <= airmc_pkg::AIRMC_H_IDLE;
                  end
               end
            end
         endcase
      end
   end

   assign link.req = req;
   assign link.we = we;
   assign link.addr = addr;
   assign link.wdata = wdata;
   assign link.hard_reset_n = hard_reset_n;
endmodule : airmc_host
`default_nettype wire

// file: test/airmc_checker_asserts.sv
// link checks for the amplifier control block
`timescale 1ns/100ps
`default_nettype none
`include "airmc_map.svh"
module airmc_checker (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // link between the two ends
   input wire logic hard_reset_n,
   input wire logic req,
   input wire logic we,
   input wire airmc_pkg::airmc_byte_t addr,
   input wire airmc_pkg::airmc_byte_t wdata,
   input wire airmc_pkg::airmc_byte_t rdata,
   input wire logic ack,
   input wire logic [9:0] irq_pin,
   input wire logic [9:0] irq_pin_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // reads, soft reset writes and shutdown writes completing in this cycle
   wire rd_ack = ack && !we;
   wire soft_go = ack && we && addr == `AIRMC_SOFT_RESET && wdata[0];
   wire shut_go = ack && we && addr == `AIRMC_POWER_CTRL && wdata[0];
   chk_boot_soft: assert property ($rose(hard_reset_n) |->
      req && we && addr == `AIRMC_SOFT_RESET && wdata[0])
      else $error("release without soft reset");
   chk_shut_first: assert property ($fell(hard_reset_n) |-> $past(shut_go))
      else $error("hard reset without shutdown");
   chk_ack_single: assert property (ack |=> !ack) else $error("ack too long");
   chk_ack_prompt: assert property ($rose(req) && hard_reset_n |=> ack) else $error("ack late");
   chk_req_release: assert property (ack |=> !req) else $error("req held after ack");
   chk_hard_quiet: assert property (!hard_reset_n |=> !ack && irq_pin_oe == 10'h000)
      else $error("device active in hard reset");
   chk_pin_enable: assert property ((irq_pin & ~irq_pin_oe) == 10'h000)
      else $error("pin high while not enabled");
   chk_soft_clears: assert property (soft_go |=> !ack ##1 irq_pin_oe == 10'h000)
      else $error("soft reset left state");
   chk_sticky_a: assert property (rd_ack && addr == `AIRMC_STICKY_A |-> (rdata & 8'h21) == 8'h00)
      else $error("stray sticky a bit");
   chk_sticky_b: assert property (rd_ack && addr == `AIRMC_STICKY_B |-> (rdata & 8'hF3) == 8'h00)
      else $error("stray sticky b bit");
   chk_self_clear: assert property (rd_ack && addr == `AIRMC_SOFT_RESET |-> rdata == 8'h00)
      else $error("reset bit reads set");
endmodule : airmc_checker
`default_nettype wire

// file: test/amp_irq_reset_mode_control_tb_top.sv
// bench driving both ends of the amplifier control block over apb
`timescale 1ns/100ps
`default_nettype none
`include "airmc_map.svh"
module amp_irq_reset_mode_control_tb_top;
   logic clock, reset, psel, penable, pwrite, pready, pslverr, perr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] flag_events;
   logic analog_power_on, battery_monitor_on, spread_on, ramp_from_oscillator;
   logic sense_power_on, sense_return_on, protection_run;
   logic [1:0] modulation_depth, ramp_frequency;
   int err_count = 0;
   int n_compared = 0;
   airmc_if airmc_if_inst ();
   airmc_device airmc_device_inst (.clock(clock), .reset(reset), .link(airmc_if_inst.device),
      .flag_events(flag_events), .analog_power_on(analog_power_on),
      .battery_monitor_on(battery_monitor_on), .spread_on(spread_on),
      .modulation_depth(modulation_depth), .ramp_from_oscillator(ramp_from_oscillator),
      .ramp_frequency(ramp_frequency), .sense_power_on(sense_power_on),
      .sense_return_on(sense_return_on), .protection_run(protection_run));
   // short quiet span keeps the run brief
   airmc_host #(.QUIET_CYCLES(8)) airmc_host_inst (.clock(clock), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(airmc_if_inst.host));
   airmc_checker airmc_checker_inst (.clock(clock), .reset(reset),
      .hard_reset_n(airmc_if_inst.hard_reset_n), .req(airmc_if_inst.req),
      .we(airmc_if_inst.we), .addr(airmc_if_inst.addr), .wdata(airmc_if_inst.wdata),
      .rdata(airmc_if_inst.rdata), .ack(airmc_if_inst.ack),
      .irq_pin(airmc_if_inst.irq_pin), .irq_pin_oe(airmc_if_inst.irq_pin_oe));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock); while (pready !== 1'h1);
      q = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
   endtask : apb
   // command writes are refused unless the host is idle
   task automatic idle;
      q = 32'h1;
      for (int i = 0; i < 60 && q[0] !== 1'h0; i++) apb(1'h0, `AIRMC_APB_STATUS, 32'h0);
   endtask : idle
   task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
      idle;
      apb(1'h1, `AIRMC_APB_CMD, {15'h0, w, d, a});
      idle;
   endtask : dev
   task automatic pulse(input logic [7:0] f);
      flag_events <= f;
      @(posedge clock);
      flag_events <= 8'h00;
      repeat (3) @(posedge clock);
   endtask : pulse
   task automatic t_boot;
      apb(1'h1, `AIRMC_APB_CTRL, 32'h0);
      dev(1'h0, `AIRMC_MODE_SEL, 8'h00);
      check(q[15:8], 8'h01);
      check({analog_power_on, battery_monitor_on, modulation_depth, sense_power_on,
         protection_run}, 6'h14);
      apb(1'h1, `AIRMC_APB_MCLK, `AIRMC_MCLK_MIN_48K);
      apb(1'h0, `AIRMC_APB_STATUS, 32'h0);
      check(q[3], 1'h1);
      dev(1'h0, `AIRMC_SOFT_RESET, 8'h00);
      check(q[15:8], 8'h00);
      apb(1'h0, 12'h010, 32'h0);
      check(perr, 1'h1);
   endtask : t_boot
   task automatic t_modes;
      dev(1'h1, `AIRMC_POWER_CTRL, 8'h00);
      for (int m = 1; m < 4; m++) begin
         dev(1'h1, `AIRMC_MODE_SEL, m[7:0]);
         check({sense_power_on, sense_return_on, protection_run},
            {m > 1, m == 2, m == 3});
      end
      apb(1'h0, `AIRMC_APB_STATUS, 32'h0);
      check(q[3], 1'h0);
   endtask : t_modes
   task automatic t_spread;
      dev(1'h1, `AIRMC_SPREAD_CTRL, 8'h01);
      check({q[1], spread_on}, 2'h2);
      dev(1'h1, `AIRMC_RAMP_CTRL, 8'h92);
      dev(1'h1, `AIRMC_SPREAD_CTRL, 8'h01);
      dev(1'h1, `AIRMC_SLEEP_CTRL, 8'h80);
      check({q[1], spread_on, ramp_from_oscillator, modulation_depth, ramp_frequency,
         battery_monitor_on}, 8'h72);
   endtask : t_spread
   task automatic t_irq;
      dev(1'h1, `AIRMC_ROUTE_BASE, 8'h01);
      dev(1'h1, `AIRMC_ROUTE_BASE + 8'h02, 8'h10);
      dev(1'h1, `AIRMC_PIN_BASE + 8'h04, `AIRMC_PIN_FN_LINE0);
      pulse(8'h08);
      check(airmc_if_inst.irq_pin, 10'h010);
      apb(1'h0, `AIRMC_APB_STATUS, 32'h0);
      check({q[25:16], q[4]}, 11'h021);
      pulse(8'h43);
      dev(1'h0, `AIRMC_STICKY_A, 8'h00);
      check(q[15:8], 8'hC8);
      check(airmc_if_inst.irq_pin, 10'h000);
      dev(1'h0, `AIRMC_STICKY_B, 8'h00);
      check(q[15:8], 8'h08);
   endtask : t_irq
   task automatic t_reset;
      dev(1'h1, `AIRMC_POWER_CTRL, 8'h01);
      dev(1'h0, `AIRMC_RAMP_CTRL, 8'h00);
      check({analog_power_on, q[15:8]}, 9'h092);
      idle;
      apb(1'h1, `AIRMC_APB_CMD, {15'h0, 1'h1, 8'h01, `AIRMC_SOFT_RESET});
      // a command inside the quiet span must be refused
      apb(1'h1, `AIRMC_APB_CMD, {15'h0, 1'h1, 8'h00, `AIRMC_POWER_CTRL});
      apb(1'h0, `AIRMC_APB_STATUS, 32'h0);
      check(q[1:0], 2'h3);
      idle;
      check({spread_on, ramp_from_oscillator, modulation_depth, ramp_frequency,
         battery_monitor_on}, 7'h09);
   endtask : t_reset
   task automatic t_hard;
      apb(1'h1, `AIRMC_APB_CTRL, 32'h1);
      repeat (10) @(posedge clock);
      apb(1'h0, `AIRMC_APB_STATUS, 32'h0);
      check({q[2], analog_power_on, airmc_if_inst.irq_pin}, 12'h800);
   endtask : t_hard
   task automatic wrap_up;
      if (err_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   initial begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end
   initial begin
      {reset, psel, penable, pwrite, paddr, pwdata, flag_events} = {1'h1, 54'h0};
      repeat (2) @(posedge clock);
      reset <= 1'h0;
      @(posedge clock);
      t_boot;
      t_modes;
      t_spread;
      t_irq;
      t_reset;
      t_hard;
      wrap_up;
   end
   // a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      wrap_up;
   end
endmodule : amp_irq_reset_mode_control_tb_top
`default_nettype wire
